// file: src/timer_cc_defines.svh
// Function
// - counter byte read snapshots both bytes
// - snapshot held until both bytes read
// - counter byte write resets counter anytime
// - counter write also clears snapshot state
// - mode bits pick capture/compare when edge-aligned; pwm modes leave pin idle
// - capture edge copies counter into value
// - capture edge selectable rising, falling, both
// - capture value byte reads are coherent
// - status/control write resets read sequence
// - capture event sets channel event flag
// - compare match sets, clears or toggles pin
// - compare value moves after both bytes
// - status/control write restarts write sequence
// - compare match sets channel event flag
// - status/control write discards pending value bytes
// - zero modulus means free run wrap
`ifndef TIMER_CC_DEFINES_SVH
`define TIMER_CC_DEFINES_SVH

`define CHAN_NUM 2

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define A_CTRL 8'h00
`define A_MOD 8'h04
`define A_CNT_HI 8'h08
`define A_CNT_LO 8'h0c
`define A_IRQ_STAT 8'h10
`define A_IRQ_MASK 8'h14
`define A_CH_BASE 8'h20
`define CH_STRIDE 8'h10
`define CH_SC 8'h00
`define CH_VH 8'h04
`define CH_VL 8'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_CALIGN 0
`define SC_FLAG 7
`define SC_IE 6
`define SC_MODE_HI 5
`define SC_MODE_LO 4
`define SC_EDGE_HI 3
`define SC_EDGE_LO 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define CNT_RST 16'h0000
`define MOD_RST 16'h0000
`define MASK_RST 2'h0

`endif

// file: src/timer_cc_pkg.sv
`default_nettype none
`include "timer_cc_defines.svh"
package timer_cc_pkg;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_COMPARE = 2'b01,
    MODE_PWM_A = 2'b10,
    MODE_PWM_B = 2'b11
  } mode_t;

  typedef struct packed {
    logic flag;
    logic ie;
    mode_t mode;
    logic [1:0] edge_sel;
    logic [15:0] val;
    logic [15:0] rbuf;
    logic [1:0] rgot;
    logic [15:0] wbuf;
    logic [1:0] wgot;
    logic pin;
    logic oe;
  } chan_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] modulus;
    logic calign;
    logic [15:0] cbuf;
    logic [1:0] cgot;
    chan_t [`CHAN_NUM-1:0] ch;
    logic [`CHAN_NUM-1:0] irq_stat;
    logic [`CHAN_NUM-1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } edge_t;

endpackage
`default_nettype wire

// file: src/chan_edge_sync.sv
`default_nettype none
module chan_edge_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  timer_cc_pkg::edge_t st_ff;
  timer_cc_pkg::edge_t nxt_st;

  // two flops before use; s1 feeds only s2
  always_comb begin
    nxt_st.s1 = pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.prev = st_ff.s2;
    if (srst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  // edges compare synchronised level with its previous value
  assign rise = st_ff.s2 & ~st_ff.prev;
  assign fall = ~st_ff.s2 & st_ff.prev;
endmodule
`default_nettype wire

// file: src/timer_cc.sv
// The address map and the APB slave port were decided locally.
`default_nettype none
`include "timer_cc_defines.svh"
module timer_cc #(
  parameter int NCH = `CHAN_NUM
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [NCH-1:0] chan_in,
  output logic [NCH-1:0] chan_out,
  output logic [NCH-1:0] chan_oe
);
  timer_cc_pkg::state_t st_ff;
  timer_cc_pkg::state_t nxt_st;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic cnt_wr;
  logic [NCH-1:0] wr_sc;
  logic [NCH-1:0] wr_vh;
  logic [NCH-1:0] ev;
  logic [15:0] tmp;
  logic [1:0] g;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // byte address of a channel register
  function automatic logic [7:0] chan_addr(input int i, input logic [7:0] off);
    chan_addr = `A_CH_BASE + 8'(i) * `CH_STRIDE + off;
  endfunction

  // pick the high or low byte of a word
  function automatic logic [7:0] pick_byte(input logic [15:0] v,
                                           input logic hi);
    pick_byte = hi ? v[15:8] : v[7:0];
  endfunction

  // mark one byte done; both done returns the sequence to idle
  function automatic logic [1:0] got_step(input logic [1:0] got,
                                          input logic hi);
    logic [1:0] s;
    s = got | (hi ? 2'b10 : 2'b01);
    got_step = (s == 2'b11) ? 2'b00 : s;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  for (genvar gi = 0; gi < NCH; gi++) begin : g_sync
    chan_edge_sync u_sync (
      .mclk(mclk),
      .srst(srst),
      .pin(chan_in[gi]),
      .rise(rise[gi]),
      .fall(fall[gi])
    );
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // one wait state: the access is acted on at its first edge, so prdata
  // comes straight from a flop when pready rises
  always_comb begin
    nxt_st = st_ff;
    acc = psel & penable & ~st_ff.pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    hit = 1'b0;
    cnt_wr = 1'b0;
    wr_sc = '0;
    wr_vh = '0;
    ev = '0;
    tmp = 16'h0000;
    g = 2'b00;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;

    // counter: zero modulus runs the full 16-bit range
    if (st_ff.modulus != 16'h0000 && st_ff.cnt == st_ff.modulus) begin
      nxt_st.cnt = 16'h0000;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end

    // register access
    if (acc) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h0000_0000;
      if (paddr == `A_CTRL) begin
        hit = 1'b1;
        if (wr) begin
          nxt_st.calign = pwdata[`CTRL_CALIGN];
        end
        nxt_st.prdata[`CTRL_CALIGN] = st_ff.calign;
      end
      if (paddr == `A_MOD) begin
        hit = 1'b1;
        if (wr) begin
          nxt_st.modulus = pwdata[15:0];
        end
        nxt_st.prdata[15:0] = st_ff.modulus;
      end
      if (paddr == `A_CNT_HI || paddr == `A_CNT_LO) begin
        hit = 1'b1;
        if (wr) begin
          // data is ignored; the count restarts from zero
          cnt_wr = 1'b1;
          nxt_st.cnt = 16'h0000;
          nxt_st.cgot = 2'b00;
        end else begin
          // fresh snapshot only when no byte of the old one is pending
          tmp = (st_ff.cgot == 2'b00) ? st_ff.cnt : st_ff.cbuf;
          nxt_st.cbuf = tmp;
          nxt_st.prdata[7:0] = pick_byte(tmp, paddr == `A_CNT_HI);
          nxt_st.cgot = got_step(st_ff.cgot, paddr == `A_CNT_HI);
        end
      end
      if (paddr == `A_IRQ_STAT) begin
        hit = 1'b1;
        nxt_st.prdata[NCH-1:0] = st_ff.irq_stat;
        if (rd) begin
          nxt_st.irq_stat = '0;
        end
      end
      if (paddr == `A_IRQ_MASK) begin
        hit = 1'b1;
        if (wr) begin
          nxt_st.irq_mask = pwdata[NCH-1:0];
        end
        nxt_st.prdata[NCH-1:0] = st_ff.irq_mask;
      end
      for (int i = 0; i < NCH; i++) begin
        if (paddr == chan_addr(i, `CH_SC)) begin
          hit = 1'b1;
          if (wr) begin
            wr_sc[i] = 1'b1;
            // flag clears by writing 0, writing 1 leaves it
            nxt_st.ch[i].flag = st_ff.ch[i].flag & pwdata[`SC_FLAG];
            nxt_st.ch[i].ie = pwdata[`SC_IE];
            nxt_st.ch[i].mode = timer_cc_pkg::mode_t'(
              pwdata[`SC_MODE_HI:`SC_MODE_LO]);
            nxt_st.ch[i].edge_sel = pwdata[`SC_EDGE_HI:`SC_EDGE_LO];
            nxt_st.ch[i].rgot = 2'b00;
            nxt_st.ch[i].wgot = 2'b00;
          end
          nxt_st.prdata[`SC_FLAG] = st_ff.ch[i].flag;
          nxt_st.prdata[`SC_IE] = st_ff.ch[i].ie;
          nxt_st.prdata[`SC_MODE_HI:`SC_MODE_LO] = st_ff.ch[i].mode;
          nxt_st.prdata[`SC_EDGE_HI:`SC_EDGE_LO] = st_ff.ch[i].edge_sel;
        end
        if (paddr == chan_addr(i, `CH_VH) ||
            paddr == chan_addr(i, `CH_VL)) begin
          hit = 1'b1;
          if (wr) begin
            // bytes gather in a buffer; active value moves on the second
            wr_vh[i] = (paddr == chan_addr(i, `CH_VH));
            tmp = st_ff.ch[i].wbuf;
            if (wr_vh[i]) begin
              tmp[15:8] = pwdata[7:0];
            end else begin
              tmp[7:0] = pwdata[7:0];
            end
            nxt_st.ch[i].wbuf = tmp;
            g = st_ff.ch[i].wgot | (wr_vh[i] ? 2'b10 : 2'b01);
            if (g == 2'b11) begin
              nxt_st.ch[i].val = tmp;
              nxt_st.ch[i].wgot = 2'b00;
            end else begin
              nxt_st.ch[i].wgot = g;
            end
          end else begin
            // both bytes latched on the first read of either
            if (st_ff.ch[i].rgot == 2'b00) begin
              tmp = st_ff.ch[i].val;
            end else begin
              tmp = st_ff.ch[i].rbuf;
            end
            nxt_st.ch[i].rbuf = tmp;
            nxt_st.prdata[7:0] = pick_byte(tmp,
              paddr == chan_addr(i, `CH_VH));
            nxt_st.ch[i].rgot = got_step(st_ff.ch[i].rgot,
              paddr == chan_addr(i, `CH_VH));
          end
        end
      end
      if (!hit) begin
        nxt_st.pslverr = 1'b1;
      end
    end

    // channel events, applied after the bus so that a set wins a clear
    for (int i = 0; i < NCH; i++) begin
      nxt_st.ch[i].oe = 1'b0;
      if (!st_ff.calign) begin
        case (st_ff.ch[i].mode)
          timer_cc_pkg::MODE_CAPTURE: begin
            if ((st_ff.ch[i].edge_sel[0] & rise[i]) |
                (st_ff.ch[i].edge_sel[1] & fall[i])) begin
              nxt_st.ch[i].val = st_ff.cnt;
              ev[i] = 1'b1;
            end
          end
          timer_cc_pkg::MODE_COMPARE: begin
            nxt_st.ch[i].oe = (st_ff.ch[i].edge_sel != 2'b00);
            if (st_ff.cnt == st_ff.ch[i].val) begin
              ev[i] = 1'b1;
              case (st_ff.ch[i].edge_sel)
                2'b01: nxt_st.ch[i].pin = ~st_ff.ch[i].pin;
                2'b10: nxt_st.ch[i].pin = 1'b0;
                2'b11: nxt_st.ch[i].pin = 1'b1;
                default: nxt_st.ch[i].pin = st_ff.ch[i].pin;
              endcase
            end
          end
          default: begin
            // pwm modes have no logic in this design; output enable held low, pin left idle
            nxt_st.ch[i].oe = 1'b0;
          end
        endcase
      end
      if (ev[i]) begin
        nxt_st.ch[i].flag = 1'b1;
        nxt_st.irq_stat[i] = 1'b1;
      end
    end

    // request from sticky status under mask, or from flag with enable
    nxt_st.irq = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if ((nxt_st.ch[i].flag & nxt_st.ch[i].ie) |
          (nxt_st.irq_stat[i] & nxt_st.irq_mask[i])) begin
        nxt_st.irq = 1'b1;
      end
    end

    if (srst) begin
      nxt_st = '0;
      nxt_st.cnt = `CNT_RST;
      nxt_st.modulus = `MOD_RST;
      nxt_st.irq_mask = `MASK_RST;
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign irq = st_ff.irq;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_out[i] = st_ff.ch[i].pin;
      chan_oe[i] = st_ff.ch[i].oe;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_CNT_WRITE_ZERO: assert property (@(posedge mclk) disable iff (srst)
    cnt_wr |=> st_ff.cnt == 16'h0000)
    else $error("counter not zero after count write");

  AST_CNT_WRITE_SEQ: assert property (@(posedge mclk) disable iff (srst)
    cnt_wr |=> st_ff.cgot == 2'b00 ##1 st_ff.cnt == 16'h0001)
    else $error("count write left snapshot state or miscounted");

  AST_SNAP_TAKE: assert property (@(posedge mclk) disable iff (srst)
    (rd && paddr == `A_CNT_HI && st_ff.cgot == 2'b00)
    |=> st_ff.cbuf == $past(st_ff.cnt) && st_ff.cgot == 2'b10
        && st_ff.prdata[7:0] == $past(st_ff.cnt[15:8]))
    else $error("counter snapshot not taken on first byte read");

  AST_SNAP_HOLD: assert property (@(posedge mclk) disable iff (srst)
    (st_ff.cgot != 2'b00 && !cnt_wr) |=> $stable(st_ff.cbuf))
    else $error("snapshot changed while a byte was pending");

  AST_FREE_WRAP: assert property (@(posedge mclk) disable iff (srst)
    (st_ff.modulus == 16'h0000 && st_ff.cnt == 16'hffff && !cnt_wr)
    |=> st_ff.cnt == 16'h0000)
    else $error("free running counter did not wrap");

  AST_CAPTURE0: assert property (@(posedge mclk) disable iff (srst)
    (!st_ff.calign && st_ff.ch[0].mode == timer_cc_pkg::MODE_CAPTURE
     && st_ff.ch[0].edge_sel[0] && rise[0])
    |=> st_ff.ch[0].val == $past(st_ff.cnt) && st_ff.ch[0].flag
        && st_ff.irq_stat[0])
    else $error("capture did not store count and flag");

  AST_SC_RESETS: assert property (@(posedge mclk) disable iff (srst)
    wr_sc[0] |=> st_ff.ch[0].rgot == 2'b00 && st_ff.ch[0].wgot == 2'b00)
    else $error("status write did not reset byte sequences");

  AST_WBUF_FIRST: assert property (@(posedge mclk) disable iff (srst)
    (wr_vh[0] && st_ff.ch[0].wgot == 2'b00 && !ev[0])
    |=> $stable(st_ff.ch[0].val) && st_ff.ch[0].wgot == 2'b10)
    else $error("single value byte reached active register");

  AST_CMP_SET0: assert property (@(posedge mclk) disable iff (srst)
    (!st_ff.calign && st_ff.ch[0].mode == timer_cc_pkg::MODE_COMPARE
     && st_ff.ch[0].edge_sel == 2'b11 && st_ff.cnt == st_ff.ch[0].val)
    |=> chan_out[0] && chan_oe[0] && st_ff.ch[0].flag)
    else $error("compare match did not set pin and flag");

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (srst)
    (st_ff.ch[0].flag && st_ff.ch[0].ie) |-> irq)
    else $error("enabled flag without interrupt");
endmodule
`default_nettype wire

// file: tb/pin_env.sv
`default_nettype none
module pin_env (
  input wire logic mclk,
  input wire logic [1:0] src_lvl,
  input wire logic [1:0] chan_out,
  input wire logic [1:0] chan_oe,
  output logic [1:0] chan_in,
  output logic [1:0] load_lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // event source: pin moves just after an edge so runs stay repeatable,
  // the design still sees it as an unsynchronised input
  initial chan_in = 2'h0;
  always @(posedge mclk) begin
    chan_in <= src_lvl;
  end

  // load with a pull-down: an undriven pin reads low, never a stale level
  assign load_lvl = chan_oe & chan_out;
endmodule
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
`include "timer_cc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] sc0_a = `A_CH_BASE + `CH_SC;
  localparam logic [7:0] vh0_a = `A_CH_BASE + `CH_VH;
  localparam logic [7:0] vl0_a = `A_CH_BASE + `CH_VL;
  typedef struct packed {
    logic [7:0] sc;
    logic to;
    logic flag;
    logic out;
  } row_t;
  row_t rows [11];
  row_t r;
  logic [7:0] ra [5];
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] src_lvl = 2'h0;
  logic [1:0] chan_in;
  logic [1:0] chan_out;
  logic [1:0] chan_oe;
  logic [1:0] load_lvl;
  logic [31:0] rd;
  logic rerr;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [15:0] vv;
  int err_count = 0;
  int num_checks = 0;

  always #5 mclk = ~mclk;

  timer_cc #(.NCH(2)) dut (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe));

  pin_env env (.mclk(mclk), .src_lvl(src_lvl), .chan_out(chan_out),
    .chan_oe(chan_oe), .chan_in(chan_in), .load_lvl(load_lvl));

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // one idle edge after each transfer so psel is never set twice at once
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) begin
      @(posedge mclk);
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic rpair(input logic [7:0] ah, input logic [7:0] al,
                       output logic [15:0] v);
    apb(1'h0, ah, 32'h0);
    v[15:8] = rd[7:0];
    apb(1'h0, al, 32'h0);
    v[7:0] = rd[7:0];
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{8'h44, 1'h1, 1'h1, 1'h0}, '{8'h44, 1'h0, 1'h0, 1'h0},
      '{8'h48, 1'h0, 1'h1, 1'h0}, '{8'h48, 1'h1, 1'h0, 1'h0},
      '{8'h4c, 1'h1, 1'h1, 1'h0}, '{8'h4c, 1'h0, 1'h1, 1'h0},
      '{8'h40, 1'h1, 1'h0, 1'h0}, '{8'h5c, 1'h0, 1'h1, 1'h1},
      '{8'h58, 1'h0, 1'h1, 1'h0}, '{8'h54, 1'h0, 1'h1, 1'h1},
      '{8'h54, 1'h0, 1'h1, 1'h0}};
    ra = '{`A_CTRL, `A_MOD, `A_IRQ_MASK, sc0_a, vh0_a};
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    foreach (ra[i]) begin
      apb(1'h0, ra[i], 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    apb(1'h1, 8'hfc, 32'h1);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    // short modulus keeps compare matches 128 cycles apart
    apb(1'h1, `A_MOD, 32'h7f);
    // capture edges and compare actions; counter restarted per row so
    // exactly one match falls inside the compare wait
    foreach (rows[i]) begin
      r = rows[i];
      vv = r.sc[4] ? 16'h0020 : 16'hffff;
      src_lvl[0] <= ~r.to;
      repeat (8) @(posedge mclk);
      apb(1'h1, sc0_a, {24'h0, r.sc});
      apb(1'h1, vh0_a, {24'h0, vv[15:8]});
      apb(1'h1, vl0_a, {24'h0, vv[7:0]});
      apb(1'h1, `A_CNT_LO, 32'ha5);
      apb(1'h1, sc0_a, {24'h0, r.sc});
      src_lvl[0] <= r.to;
      repeat (r.sc[4] ? 64 : 8) @(posedge mclk);
      chk("irq", {31'h0, irq}, {31'h0, r.flag});
      chk("pin", {31'h0, load_lvl[0]}, {31'h0, r.out});
      chk("oe", {31'h0, chan_oe[0]}, {31'h0, r.sc[4]});
      apb(1'h0, sc0_a, 32'h0);
      chk("flag", {31'h0, rd[`SC_FLAG]}, {31'h0, r.flag});
      rpair(vh0_a, vl0_a, v1);
      if (r.sc[4] == 1'h0 && r.flag == 1'h1) begin
        chk("capture", {31'h0, v1 != 16'h0 && v1 < 16'h0020}, 32'h1);
      end else begin
        chk("value", {16'h0, v1}, {16'h0, vv});
      end
    end
    // a half-written value is dropped by a status/control write
    apb(1'h1, vh0_a, 32'h12);
    apb(1'h1, sc0_a, 32'h54);
    apb(1'h1, vl0_a, 32'h34);
    rpair(vh0_a, vl0_a, v1);
    chk("value_drop", {16'h0, v1}, 32'h20);
    apb(1'h1, vh0_a, 32'h0);
    rpair(vh0_a, vl0_a, v1);
    chk("value_pair", {16'h0, v1}, 32'h34);
    apb(1'h1, `A_CTRL, 32'h1);
    chk("calign_oe", {31'h0, chan_oe[0]}, 32'h0);
    apb(1'h1, `A_CTRL, 32'h0);
    // sticky status, mask and read-clear; value parked out of reach
    apb(1'h1, sc0_a, 32'h0);
    apb(1'h1, vh0_a, 32'hff);
    apb(1'h1, vl0_a, 32'hff);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'h1, `A_IRQ_MASK, 32'h1);
    chk("irq_unmasked", {31'h0, irq}, 32'h1);
    apb(1'h0, `A_IRQ_STAT, 32'h0);
    chk("stat_set", {31'h0, rd[0]}, 32'h1);
    apb(1'h0, `A_IRQ_STAT, 32'h0);
    chk("stat_clear", {31'h0, rd[0]}, 32'h0);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    // counter snapshot: gap above 256 forces the high byte to move
    apb(1'h1, `A_MOD, 32'h0);
    apb(1'h0, `A_CNT_LO, 32'h0);
    v1[7:0] = rd[7:0];
    repeat (300) @(posedge mclk);
    apb(1'h0, `A_CNT_HI, 32'h0);
    v1[15:8] = rd[7:0];
    rpair(`A_CNT_HI, `A_CNT_LO, v2);
    vv = v2 - v1;
    chk("snapshot", {31'h0, vv >= 16'h012c && vv <= 16'h014a}, 32'h1);
    repeat (65536) @(posedge mclk);
    rpair(`A_CNT_HI, `A_CNT_LO, v1);
    vv = v1 - v2;
    chk("wrap", {31'h0, vv != 16'h0 && vv <= 16'h0014}, 32'h1);
    // counter write mid-snapshot restarts both count and sequence
    apb(1'h0, `A_CNT_HI, 32'h0);
    apb(1'h1, `A_CNT_HI, 32'ha5);
    apb(1'h0, `A_CNT_LO, 32'h0);
    chk("clr_low", {31'h0, rd[7:0] <= 8'h10}, 32'h1);
    apb(1'h0, `A_CNT_HI, 32'h0);
    chk("clr_high", {24'h0, rd[7:0]}, 32'h0);
    report_and_stop();
  end

  // watchdog sized well above the 67k cycles the sequence needs
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
